// ===== rtl/wlr_pkg.sv
`default_nettype none
package wlr_pkg;
    localparam int DATA_W = 16;
    localparam int IN_W   = 32;
    localparam int AXI_AW = 4;
    localparam int MODE_W = 3;
    localparam int KIND_W = 2;

    ////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam logic [AXI_AW-1:0] OFS_CTRL   = 4'h0;
    localparam logic [AXI_AW-1:0] OFS_INIT   = 4'h4;
    localparam logic [AXI_AW-1:0] OFS_CMD    = 4'h8;
    localparam logic [AXI_AW-1:0] OFS_STATUS = 4'hc;

    // field positions
    localparam int CTRL_MODE_LSB     = 0;
    localparam int CTRL_PERSIST_BIT  = 3;
    localparam int CTRL_LOADINIT_BIT = 4;
    localparam int CTRL_USED_W       = 5;
    localparam int CMD_LOAD_BIT      = 0;
    localparam int STAT_RESTORED_BIT = 16;
    localparam int STAT_RUN_BIT      = 17;
    localparam int FRAC_BITS         = 16;

    // reset values
    localparam logic [DATA_W-1:0]      INIT_DEFAULT = 16'h0000;
    localparam logic [CTRL_USED_W-1:0] CTRL_RESET   = 5'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [MODE_W-1:0] {
        MODE_HIGH = 3'h0,
        MODE_LOW  = 3'h1,
        MODE_RISE = 3'h2,
        MODE_FALL = 3'h3,
        MODE_BOTH = 3'h4
    } wlr_mode_t;

    typedef enum logic [KIND_W-1:0] {
        KIND_WORD   = 2'h0,
        KIND_BINARY = 2'h1,
        KIND_LONG   = 2'h2,
        KIND_ANALOG = 2'h3
    } wlr_kind_t;

    typedef enum logic [1:0] {
        ST_BOOT = 2'h1,
        ST_RUN  = 2'h2
    } wlr_state_t;
endpackage
`default_nettype wire

// ===== rtl/wlr_strobe_edge.sv
`default_nettype none
module wlr_strobe_edge (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic strobe,
    output logic      rise,
    output logic      fall,
    output logic      prev
);
    import wlr_pkg::*;

    logic prev_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= strobe;
        end
    end

    // edges against last cycle's sample
    assign rise = strobe & ~prev_reg;
    assign fall = ~strobe & prev_reg;
    assign prev = prev_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_rise_single: assert property (rise |=> !rise)
        else $error("rise edge lasted two cycles");
    // a strobe that drops across reset is no edge: the sample was cleared
    a_fall_after_high: assert property (($fell(strobe) & $past(aresetn)) |-> fall)
        else $error("falling strobe not flagged");
endmodule
`default_nettype wire

// ===== rtl/wlr_convert.sv
`default_nettype none
module wlr_convert (
    input  wire logic [wlr_pkg::IN_W-1:0]   data_in,
    input  wire logic [wlr_pkg::KIND_W-1:0] data_kind,
    output logic      [wlr_pkg::DATA_W-1:0] word_out
);
    import wlr_pkg::*;

    localparam logic [IN_W-1:0]   IN_ONE   = 32'h0000_0001;
    localparam logic [DATA_W-1:0] WORD_ONE = 16'h0001;

    logic              neg;
    logic [IN_W-1:0]   mag;
    logic [DATA_W-1:0] int_mag;
    logic [DATA_W-1:0] ana_word;
    logic [DATA_W-1:0] bin_word;

    // analog is signed fixed point; magnitude first so truncation goes toward zero
    assign neg      = data_in[IN_W-1];
    assign mag      = neg ? (~data_in + IN_ONE) : data_in;
    assign int_mag  = mag[FRAC_BITS +: DATA_W];
    assign ana_word = neg ? (~int_mag + WORD_ONE) : int_mag;
    assign bin_word = {{(DATA_W-1){1'b0}}, |data_in};
    assign word_out = (data_kind == KIND_BINARY) ? bin_word :
                      (data_kind == KIND_ANALOG) ? ana_word :
                      data_in[DATA_W-1:0];
endmodule
`default_nettype wire

// ===== rtl/wlr_top.sv
// Overview of operation
// - The stored value is a 16-bit signed integer.
// - The held word output always shows the stored register value.
// - In level-high mode the input is copied every cycle the strobe is one.
// - In level-low mode the input is copied every cycle the strobe is zero.
// - A strobe marked as not connected counts as a constant zero.
// - In rising-edge mode the input is copied only when the strobe goes from zero to one.
// - In falling-edge mode the input is copied only when the strobe goes from one to zero.
// - In both-edges mode the input is copied whenever the strobe changes level.
// - A configurable initial value is loaded into storage at startup.
// - With persistence on, the last saved value is kept outside and restored at power-up.
// - Binary inputs become 0 or 1, fractions truncate toward zero, wide integers keep low 16 bits.
`default_nettype none
module wlr_top (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [wlr_pkg::AXI_AW-1:0]   s_axi_awaddr,
    input  wire logic [2:0]                   s_axi_awprot,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [wlr_pkg::AXI_AW-1:0]   s_axi_araddr,
    input  wire logic [2:0]                   s_axi_arprot,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire logic [wlr_pkg::IN_W-1:0]     data_in,
    input  wire logic [wlr_pkg::KIND_W-1:0]   data_kind,
    input  wire logic                         capture_strobe,
    input  wire logic                         strobe_connected,
    input  wire logic [wlr_pkg::DATA_W-1:0]   nv_word_in,
    input  wire logic                         nv_valid_in,
    output logic      [wlr_pkg::DATA_W-1:0]   held_word_out,
    output logic                              nv_save_strobe,
    output logic      [wlr_pkg::DATA_W-1:0]   nv_save_word
);
    import wlr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // byte-lane merge, used by both writable registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] val,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [AXI_AW-1:0]      aw_addr_reg;
    logic                   aw_full_reg;
    logic [31:0]            w_data_reg;
    logic [3:0]             w_strb_reg;
    logic                   w_full_reg;
    logic                   awready_reg;
    logic                   wready_reg;
    logic                   bvalid_reg;
    logic [1:0]             bresp_reg;
    logic                   arready_reg;
    logic                   rvalid_reg;
    logic [31:0]            rdata_reg;
    logic [1:0]             rresp_reg;
    logic [CTRL_USED_W-1:0] ctrl_reg;
    logic [DATA_W-1:0]      init_reg;
    logic [DATA_W-1:0]      storage_reg;
    logic [DATA_W-1:0]      storage_next;
    logic                   restored_reg;
    logic                   restored_next;
    logic                   save_strobe_reg;
    logic [DATA_W-1:0]      save_word_reg;
    wlr_state_t             state_reg;
    wlr_state_t             state_next;

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write side: address and data land independently
    logic              aw_take;
    logic              w_take;
    logic              do_write;
    logic              aw_full_next;
    logic              w_full_next;
    logic              bvalid_next;
    logic              wr_ctrl;
    logic              wr_init;
    logic              wr_cmd;
    logic              wr_hit;
    logic [31:0]       ctrl_merged;
    logic [31:0]       init_merged;

    assign aw_take      = s_axi_awvalid & awready_reg;
    assign w_take       = s_axi_wvalid & wready_reg;
    assign do_write     = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign aw_full_next = do_write ? 1'b0 : (aw_full_reg | aw_take);
    assign w_full_next  = do_write ? 1'b0 : (w_full_reg | w_take);
    assign bvalid_next  = do_write | (bvalid_reg & ~s_axi_bready);
    assign wr_ctrl      = do_write & (aw_addr_reg == OFS_CTRL);
    assign wr_init      = do_write & (aw_addr_reg == OFS_INIT);
    assign wr_cmd       = do_write & (aw_addr_reg == OFS_CMD);
    assign wr_hit       = wr_ctrl | wr_init | wr_cmd;
    assign ctrl_merged  = lane_merge({{(32-CTRL_USED_W){1'b0}}, ctrl_reg}, w_data_reg, w_strb_reg);
    assign init_merged  = lane_merge({{(32-DATA_W){1'b0}}, init_reg}, w_data_reg, w_strb_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_reg <= '0;
            aw_full_reg <= 1'b0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
            w_full_reg  <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            aw_full_reg <= aw_full_next;
            w_full_reg  <= w_full_next;
            awready_reg <= ~aw_full_next & ~bvalid_next;
            wready_reg  <= ~w_full_next & ~bvalid_next;
            bvalid_reg  <= bvalid_next;
            if (do_write) begin
                bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read side: one cycle from address to data
    logic        ar_take;
    logic        rvalid_next;
    logic        rd_hit;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    assign ar_take     = s_axi_arvalid & arready_reg;
    assign rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
    assign status_word = {14'h0000, (state_reg == ST_RUN), restored_reg, storage_reg};
    assign rd_hit      = (s_axi_araddr == OFS_CTRL) | (s_axi_araddr == OFS_INIT) |
                         (s_axi_araddr == OFS_CMD) | (s_axi_araddr == OFS_STATUS);
    assign rd_mux      = (s_axi_araddr == OFS_CTRL)   ? {{(32-CTRL_USED_W){1'b0}}, ctrl_reg} :
                         (s_axi_araddr == OFS_INIT)   ? {{(32-DATA_W){1'b0}}, init_reg} :
                         (s_axi_araddr == OFS_STATUS) ? status_word :
                         32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_next;
            rvalid_reg  <= rvalid_next;
            if (ar_take) begin
                rdata_reg <= rd_mux;
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= CTRL_RESET;
            init_reg <= INIT_DEFAULT;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= ctrl_merged[CTRL_USED_W-1:0];
            end
            if (wr_init) begin
                init_reg <= init_merged[DATA_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobe conditioning and capture decision
    logic              strobe_eff;
    logic              edge_rise;
    logic              edge_fall;
    logic              strobe_prev;
    logic [DATA_W-1:0] conv_word;
    logic              running;
    logic              capture_fire;
    logic              persist_on;
    logic              new_persist;
    logic              boot_exit;
    logic              proj_load;
    wlr_mode_t         mode;

    // a floating strobe would be x in silicon, so the neighbour marks it instead
    assign strobe_eff = capture_strobe & strobe_connected;

    wlr_strobe_edge u_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .strobe  (strobe_eff),
        .rise    (edge_rise),
        .fall    (edge_fall),
        .prev    (strobe_prev)
    );

    wlr_convert u_conv (
        .data_in   (data_in),
        .data_kind (data_kind),
        .word_out  (conv_word)
    );

    assign mode         = wlr_mode_t'(ctrl_reg[CTRL_MODE_LSB +: MODE_W]);
    assign running      = (state_reg == ST_RUN);
    assign persist_on   = ctrl_reg[CTRL_PERSIST_BIT];
    assign new_persist  = ctrl_merged[CTRL_PERSIST_BIT];
    assign boot_exit    = (state_reg == ST_BOOT) & wr_ctrl;
    assign proj_load    = running & wr_cmd & w_strb_reg[0] & w_data_reg[CMD_LOAD_BIT];
    // unused mode codes capture nothing rather than guess
    assign capture_fire = running & (
                          ((mode == MODE_HIGH) & strobe_eff) |
                          ((mode == MODE_LOW) & ~strobe_eff) |
                          ((mode == MODE_RISE) & edge_rise) |
                          ((mode == MODE_FALL) & edge_fall) |
                          ((mode == MODE_BOTH) & (edge_rise | edge_fall)));

    ////////////////////////////////////////////////////////////////////////
    // state machine: captures wait until software has configured the block
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_BOOT: begin
                if (wr_ctrl) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_BOOT;
            end
        endcase
    end

    // priority: power-up restore, then project load, then capture
    always_comb begin
        storage_next  = storage_reg;
        restored_next = restored_reg;
        if (boot_exit) begin
            if (new_persist & nv_valid_in) begin
                storage_next  = nv_word_in;
                restored_next = 1'b1;
            end else begin
                storage_next = init_reg;
            end
        end else if (proj_load) begin
            if (persist_on & ~ctrl_reg[CTRL_LOADINIT_BIT] & nv_valid_in) begin
                storage_next  = nv_word_in;
                restored_next = 1'b1;
            end else begin
                storage_next  = init_reg;
                restored_next = 1'b0;
            end
        end else if (capture_fire) begin
            storage_next = conv_word;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg       <= ST_BOOT;
            storage_reg     <= INIT_DEFAULT;
            restored_reg    <= 1'b0;
            save_strobe_reg <= 1'b0;
            save_word_reg   <= INIT_DEFAULT;
        end else begin
            state_reg       <= state_next;
            storage_reg     <= storage_next;
            restored_reg    <= restored_next;
            // save only on change to spare the outside memory's endurance
            save_strobe_reg <= (persist_on | new_persist & wr_ctrl) & (storage_next != storage_reg);
            save_word_reg   <= storage_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign s_axi_awready  = awready_reg;
    assign s_axi_wready   = wready_reg;
    assign s_axi_bvalid   = bvalid_reg;
    assign s_axi_bresp    = bresp_reg;
    assign s_axi_arready  = arready_reg;
    assign s_axi_rvalid   = rvalid_reg;
    assign s_axi_rdata    = rdata_reg;
    assign s_axi_rresp    = rresp_reg;
    assign held_word_out  = storage_reg;
    assign nv_save_strobe = save_strobe_reg;
    assign nv_save_word   = save_word_reg;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_hold_stable: assert property ((running & ~capture_fire & ~proj_load) |=> $stable(held_word_out))
        else $error("held word changed without cause");
    a_level_high: assert property ((running & mode == MODE_HIGH & strobe_eff & ~proj_load)
                                   |=> held_word_out == $past(conv_word))
        else $error("high level did not capture");
    a_level_low: assert property ((running & mode == MODE_LOW & ~strobe_eff & ~proj_load)
                                  |=> held_word_out == $past(conv_word))
        else $error("low level did not capture");
    a_floating_low: assert property ((running & mode == MODE_HIGH & ~strobe_connected & ~proj_load)
                                     |=> $stable(held_word_out))
        else $error("unconnected strobe acted as high");
    a_rise_only: assert property ((running & mode == MODE_RISE & ~($rose(strobe_eff)) & ~proj_load)
                                  |=> $stable(held_word_out))
        else $error("rising mode captured without rise");
    a_fall_take: assert property ((running & mode == MODE_FALL & $fell(strobe_eff) & ~proj_load)
                                  |=> held_word_out == $past(conv_word))
        else $error("falling edge did not capture");
    a_both_edges: assert property ((running & mode == MODE_BOTH & (strobe_eff != strobe_prev) & ~proj_load)
                                   |=> held_word_out == $past(conv_word))
        else $error("edge in both mode not captured");
    a_startup_init: assert property ((boot_exit & ~new_persist) |=> held_word_out == $past(init_reg))
        else $error("startup did not load initial value");
    a_boot_restore: assert property ((boot_exit & new_persist & nv_valid_in)
                                     |=> (held_word_out == $past(nv_word_in)) ##1 nv_save_strobe == 1'b0)
        else $error("saved value not restored");
    a_project_init: assert property ((proj_load & persist_on & ctrl_reg[CTRL_LOADINIT_BIT])
                                     |=> held_word_out == $past(init_reg))
        else $error("project load ignored initial option");
    a_long_low16: assert property ((running & mode == MODE_HIGH & strobe_eff & data_kind == KIND_LONG & ~proj_load)
                                   |=> held_word_out == $past(data_in[DATA_W-1:0]))
        else $error("long input not cut to low bits");
    a_edge_source: assert property ($rose(strobe_eff) |-> edge_rise)
        else $error("rise not seen against previous sample");
    a_reset_load: assert property (disable iff (1'b0) !aresetn |=> (held_word_out == INIT_DEFAULT & ~strobe_prev))
        else $error("reset did not load initial value");

    c_rise_capture: cover property (running & mode == MODE_RISE & capture_fire);
    c_boot_restore: cover property (boot_exit & new_persist & nv_valid_in);
    c_project_load: cover property (proj_load & persist_on);
    c_analog_neg:   cover property (capture_fire & data_kind == KIND_ANALOG & data_in[IN_W-1]);
endmodule
`default_nettype wire

// ===== tb/wlr_nv_model.sv
`default_nettype none
module wlr_nv_model (
    input  wire logic                       aclk,
    input  wire logic                       save_stb,
    input  wire logic [wlr_pkg::DATA_W-1:0] save_word,
    output logic      [wlr_pkg::DATA_W-1:0] word_out,
    output logic                            valid_out
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////
    // no reset on purpose: contents outlive power loss
    initial begin
        word_out = 16'h0000;
        valid_out = 1'b0;
    end
    always @(posedge aclk) begin
        if (save_stb) begin
            word_out <= save_word;
            valid_out <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/word_latch_register_bench.sv
`default_nettype none
module word_latch_register_bench import wlr_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, strobe, conn, nv_valid, awready;
    logic        wready, bvalid, arready, rvalid, save_stb;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, data_in;
    logic [1:0]  bresp, rresp, kind;
    logic [15:0] held, nv_word, save_word;
    int          n_fail, compares;
    wlr_kind_t   cv_k[5] = '{KIND_ANALOG, KIND_LONG, KIND_BINARY, KIND_WORD, KIND_ANALOG};
    logic [31:0] cv_d[5] = '{32'h0062e666, 32'h00013880, 32'h00000004, 32'habcd0007, 32'hfffe8000};
    logic [15:0] cv_e[5] = '{16'h0062, 16'h3880, 16'h0001, 16'h0007, 16'hffff};
    wlr_mode_t   md[12] = '{MODE_LOW, MODE_LOW, MODE_LOW, MODE_RISE, MODE_RISE, MODE_RISE,
                            MODE_FALL, MODE_FALL, MODE_FALL, MODE_BOTH, MODE_BOTH, MODE_BOTH};
    logic        st[12] = '{1, 0, 1, 0, 1, 1, 1, 0, 0, 1, 0, 0};
    logic [15:0] ex[12] = '{7, 9, 10, 10, 12, 12, 12, 15, 15, 17, 18, 18};
    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    wlr_top dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .data_in(data_in), .data_kind(kind), .capture_strobe(strobe), .strobe_connected(conn),
        .nv_word_in(nv_word), .nv_valid_in(nv_valid), .held_word_out(held), .nv_save_strobe(save_stb),
        .nv_save_word(save_word));
    wlr_nv_model nv (.aclk(aclk), .save_stb(save_stb), .save_word(save_word), .word_out(nv_word),
        .valid_out(nv_valid));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // every bus wait shares one bound so a dead slave cannot hang the run
    task automatic guard(input int n);
        if (n >= 40) begin
            n_fail++;
            $display("[FAIL] t=%0t bus wait ran out", $time);
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid} <= 2'h3;
        do begin
            @(posedge aclk);
            n++;
            bready <= 1'b1;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!((!awvalid || awready) && (!wvalid || wready)) && n < 40);
        do begin
            @(posedge aclk);
            n++;
        end while (!bvalid && n < 40);
        bready <= 1'b0;
        guard(n);
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        int n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            rready <= 1'b1;
        end while (!arready && n < 40);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (!rvalid && n < 40);
        rready <= 1'b0;
        guard(n);
        chk(rdata, e);
        chk(32'(rresp), 32'(RESP_OKAY));
    endtask
    task automatic cap(input logic s, input logic [31:0] d, input logic [15:0] e);
        strobe <= s;
        data_in <= d;
        repeat (2) @(posedge aclk);
        chk(32'(held), 32'(e));
    endtask
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {n_fail, compares} = '0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, strobe} = '0;
        {awaddr, araddr, wdata, data_in, kind} = '0;
        conn = 1'b1;
        do_reset();
        chk(32'(held), 32'(INIT_DEFAULT));
        rd(OFS_STATUS, 32'h0);
        wr(OFS_INIT, 32'h1234, RESP_OKAY);
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
        chk(32'(held), 32'h1234);
        foreach (cv_d[i]) begin
            kind <= cv_k[i];
            cap(1'b1, cv_d[i], cv_e[i]);
        end
        kind <= KIND_WORD;
        cap(1'b0, 32'h7, 16'hffff);
        for (int i = 0; i < 12; i++) begin
            if (i == 0 || md[i] != md[i - 1]) wr(OFS_CTRL, 32'(md[i]), RESP_OKAY);
            conn <= (i != 2);
            cap(st[i], 32'(i + 8), ex[i]);
        end
        wr(OFS_CTRL, 32'h08, RESP_OKAY);
        cap(1'b1, 32'h77, 16'h77);
        // the outside store takes the word one edge after the save pulse
        @(posedge aclk);
        chk(32'(nv_word), 32'h77);
        do_reset();
        chk(32'(held), 32'h0);
        // fall mode keeps a high strobe from capturing during the restore
        wr(OFS_CTRL, 32'h0b, RESP_OKAY);
        rd(OFS_STATUS, 32'h00030077);
        wr(OFS_INIT, 32'h55, RESP_OKAY);
        wr(OFS_CTRL, 32'h13, RESP_OKAY);
        wr(OFS_CMD, 32'h1, RESP_OKAY);
        wr(OFS_CTRL, 32'h0b, RESP_OKAY);
        wr(OFS_CMD, 32'h1, RESP_OKAY);
        chk(32'(held), 32'h77);
        wr(OFS_CTRL, 32'h1b, RESP_OKAY);
        wr(OFS_CMD, 32'h1, RESP_OKAY);
        chk(32'(held), 32'h55);
        wr(OFS_STATUS, 32'h0, RESP_SLVERR);
        rd(OFS_STATUS, 32'h00020055);
        // spare mode code: a falling strobe must not capture
        wr(OFS_CTRL, 32'h05, RESP_OKAY);
        cap(1'b0, 32'h99, 16'h55);
        report_and_stop();
    end
endmodule
`default_nettype wire
